/* rtl/timer_w_irq_flags.sv */
// Function
// - overflow request active only while overflow enable and overflow flag are both one
// - each channel request active only while its enable and its event flag are one
// - enables and flags reset to zero; enables are read/write
// - reserved bits 6..4 of both registers read one, writes ignored
// - status: overflow bit 7, channel D..A flags in bits 3..0
// - overflow flag sets when the counter wraps from all ones to zero
// - overflow flag clears only after read as one then write zero
// - compare channel flag sets when counter equals its general register
// - capture channel flag sets when a capture loads its general register
// - channel flag clears only after read as one then write zero
// - writing one to a flag leaves it unchanged; software cannot set flags
// - function bit zero selects compare, one selects capture setting condition
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
module timer_w_irq_flags
  import timer_w_irq_pkg::*;
(
  input wire logic core_clk, // 250 MHz peripheral clock
  input wire logic reset, // asynchronous, active high
  input wire reg_req_t reg_req, // address, write data and strobes
  output logic [DATA_W-1:0] reg_rdata, // read data, valid the cycle after reg_req.rd
  input wire logic [CNT_W-1:0] timer_counter, // current counter value
  input wire logic count_tick, // counter took a new value this cycle
  input wire logic [CNT_W-1:0] general_reg_a, // channel A general register
  input wire logic [CNT_W-1:0] general_reg_b, // channel B general register
  input wire logic [CNT_W-1:0] general_reg_c, // channel C general register
  input wire logic [CNT_W-1:0] general_reg_d, // channel D general register
  input wire logic chan_a_capture_select, // 1: channel A is input capture
  input wire logic chan_b_capture_select, // 1: channel B is input capture
  input wire logic chan_c_capture_select, // 1: channel C is input capture
  input wire logic chan_d_capture_select, // 1: channel D is input capture
  input wire logic [NUM_CHAN-1:0] capture_strobe, // pulse: counter copied into channel d..a
  output irq_req_t irq_req // level requests, registered
);

  // stored state: bit 4 is overflow, bits 3..0 are channels D..A
  logic [NUM_FLAG-1:0] enable_q, enable_d;
  logic [NUM_FLAG-1:0] flag_q, flag_d;
  logic [NUM_FLAG-1:0] armed_q, armed_d;
  logic [NUM_FLAG-1:0] req_q, req_d;
  logic [CNT_W-1:0] prev_count_q;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  // per-channel views gathered into vectors for the loop below
  logic [CNT_W-1:0] gen_reg [NUM_CHAN];
  logic [NUM_CHAN-1:0] capture_sel;
  logic [NUM_CHAN-1:0] chan_match;
  logic [NUM_CHAN-1:0] chan_set;
  logic overflow_set;
  logic [NUM_FLAG-1:0] set_ev;

  assign gen_reg[0] = general_reg_a;
  assign gen_reg[1] = general_reg_b;
  assign gen_reg[2] = general_reg_c;
  assign gen_reg[3] = general_reg_d;
  assign capture_sel = {chan_d_capture_select, chan_c_capture_select,
                        chan_b_capture_select, chan_a_capture_select};

  // register decode
  wire enable_sel = (reg_req.addr == TIMER_IRQ_ENABLE_OFS);
  wire status_sel = (reg_req.addr == TIMER_IRQ_STATUS_OFS);
  wire enable_wr = reg_req.wr && enable_sel;
  wire status_wr = reg_req.wr && status_sel;
  wire status_rd = reg_req.rd && status_sel;

  // write data bits that land on stored fields; reserved bits are dropped
  wire [NUM_FLAG-1:0] wr_fields = {reg_req.wdata[OVERFLOW_BIT],
                                   reg_req.wdata[CHAN_D_BIT],
                                   reg_req.wdata[CHAN_C_BIT],
                                   reg_req.wdata[CHAN_B_BIT],
                                   reg_req.wdata[CHAN_A_BIT]};

  // wrap detect: the tick that follows an all-ones count landing on zero.
  // a load of zero from any other value is not an overflow.
  assign overflow_set = count_tick && (timer_counter == COUNT_ZERO)
                        && (prev_count_q == COUNT_MAX);

  // per-channel setting condition; the function bit picks which one applies
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      // compare fires once per count, on the tick that reaches the value
      assign chan_match[ch] = count_tick && (timer_counter == gen_reg[ch]);
      assign chan_set[ch] = capture_sel[ch] ? capture_strobe[ch]
                                            : chan_match[ch];
    end
  endgenerate

  assign set_ev = {overflow_set, chan_set};

  // a write of zero clears only a flag that an earlier status read saw as one;
  // ones written are ignored, so software can never set a flag
  wire [NUM_FLAG-1:0] clear_req = status_wr ? (armed_q & ~wr_fields)
                                            : {NUM_FLAG{1'b0}};

  // set beats clear in the same cycle so no event is lost
  assign flag_d = (flag_q & ~clear_req) | set_ev;

  // arming: a status read records which flags it returned as one. any status
  // write consumes the arming, so a stale read cannot clear a later event.
  always_comb begin
    armed_d = armed_q;
    if (status_wr) begin
      armed_d = {NUM_FLAG{1'b0}};
    end else if (status_rd) begin
      armed_d = armed_q | flag_q;
    end
  end

  // enables are plain read/write fields
  assign enable_d = enable_wr ? wr_fields : enable_q;

  // requests follow next-state values so the output flop drops the same
  // cycle the flag or enable flop clears, at the cost of a wider cone
  assign req_d = flag_d & enable_d;

  // read mux; reserved bits read one, unmapped addresses read zero
  wire [DATA_W-1:0] enable_view = RESERVED_MASK
    | (DATA_W'(enable_q[OVF_IDX]) << OVERFLOW_BIT)
    | DATA_W'(enable_q[NUM_CHAN-1:0]);
  wire [DATA_W-1:0] status_view = RESERVED_MASK
    | (DATA_W'(flag_q[OVF_IDX]) << OVERFLOW_BIT)
    | DATA_W'(flag_q[NUM_CHAN-1:0]);

  always_comb begin
    rdata_d = UNMAPPED_READ;
    if (reg_req.rd) begin
      if (enable_sel) begin
        rdata_d = enable_view;
      end else if (status_sel) begin
        rdata_d = status_view;
      end else begin
        rdata_d = UNMAPPED_READ;
      end
    end
  end

  // control state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      enable_q <= ENABLE_RESET;
      flag_q <= FLAG_RESET;
      armed_q <= '0;
      req_q <= '0;
    end else begin
      enable_q <= enable_d;
      flag_q <= flag_d;
      armed_q <= armed_d;
      req_q <= req_d;
    end
  end

  // counter history and read data; read data stands one cycle only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prev_count_q <= COUNT_ZERO;
      rdata_q <= UNMAPPED_READ;
    end else begin
      prev_count_q <= timer_counter;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_req.overflow_irq_req = req_q[OVF_IDX];
  assign irq_req.chan_d_irq_req = req_q[CHAN_D_BIT];
  assign irq_req.chan_c_irq_req = req_q[CHAN_C_BIT];
  assign irq_req.chan_b_irq_req = req_q[CHAN_B_BIT];
  assign irq_req.chan_a_irq_req = req_q[CHAN_A_BIT];

endmodule // timer_w_irq_flags

/* rtl/timer_w_irq_pkg.sv */
package timer_w_irq_pkg;

  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int NUM_CHAN = 4;
  localparam int NUM_FLAG = 5;

  // register offsets
  localparam logic [ADDR_W-1:0] TIMER_IRQ_ENABLE_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] TIMER_IRQ_STATUS_OFS = 4'h1;

  // field positions, shared by the enable and status registers
  localparam int OVERFLOW_BIT = 7;
  localparam int CHAN_D_BIT = 3;
  localparam int CHAN_C_BIT = 2;
  localparam int CHAN_B_BIT = 1;
  localparam int CHAN_A_BIT = 0;

  // reserved bits 6..4 read as one
  localparam logic [DATA_W-1:0] RESERVED_MASK = 8'h70;

  // reset values of the stored fields
  localparam logic [NUM_FLAG-1:0] ENABLE_RESET = 5'h00;
  localparam logic [NUM_FLAG-1:0] FLAG_RESET = 5'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // index of the overflow flag inside the internal flag vector
  localparam int OVF_IDX = 4;

  // counter wrap values
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;

  // interrupt request lines to the interrupt controller
  typedef struct packed {
    logic overflow_irq_req;
    logic chan_d_irq_req;
    logic chan_c_irq_req;
    logic chan_b_irq_req;
    logic chan_a_irq_req;
  } irq_req_t;

  // one register access from software
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

/* verification/timer_count_model.sv */
`timescale 1ns/1ps
// counter stand-in: ticks on a load and on each counting cycle, holds otherwise
module timer_count_model (
  input wire logic core_clk, // clock
  input wire logic reset, // async reset
  input wire logic load, // load start
  input wire logic run, // count up
  input wire logic [15:0] start, // load value
  output logic [15:0] timer_counter, // count
  output logic count_tick // new value
);
  // value never moves without a tick, so a stale all-ones cannot fake a wrap
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      timer_counter <= 16'h0000;
      count_tick <= 1'b0;
    end else begin
      count_tick <= load || run;
      if (load)
        timer_counter <= start;
      else if (run)
        timer_counter <= timer_counter + 16'h0001;
    end
  end
endmodule // timer_count_model

/* verification/timer_w_irq_flags_chk.sv */
`timescale 1ns/1ps
module timer_w_irq_flags_chk
  import timer_w_irq_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic reset, // async reset
  input wire reg_req_t reg_req, // bus
  input wire logic [DATA_W-1:0] reg_rdata, // read data
  input wire logic [CNT_W-1:0] timer_counter, // count
  input wire logic count_tick, // tick
  input wire logic [CNT_W-1:0] general_reg_a, // chan a
  input wire logic [CNT_W-1:0] general_reg_b, // chan b
  input wire logic chan_a_capture_select, // a mode
  input wire logic chan_b_capture_select, // b mode
  input wire logic [NUM_CHAN-1:0] capture_strobe, // captures
  input wire irq_req_t irq_req // requests
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // causes a request may rise or fall on; anything else is a fault
  wire en_w = reg_req.wr && reg_req.addr == TIMER_IRQ_ENABLE_OFS;
  wire sa = count_tick && timer_counter == general_reg_a && !chan_a_capture_select
    || capture_strobe[0] && chan_a_capture_select || en_w && reg_req.wdata[0];
  wire evb = count_tick && timer_counter == general_reg_b && !chan_b_capture_select
    || capture_strobe[1] && chan_b_capture_select;
  wire sb = evb || en_w && reg_req.wdata[1];
  wire ovt = count_tick && timer_counter == COUNT_ZERO;
  wire sov = en_w && reg_req.wdata[OVERFLOW_BIT];
  wire ca = reg_req.wr && reg_req.addr < 4'h2 && !reg_req.wdata[0];
  wire co = reg_req.wr && reg_req.addr < 4'h2 && !reg_req.wdata[OVERFLOW_BIT];
  wire rdm = reg_req.rd && reg_req.addr < 4'h2;
  rst_quiet_a: assert property (disable iff (1'b0) reset |-> irq_req == '0)
    else $error("request active in reset");
  rsvd_ones_a: assert property ($past(rdm) |-> reg_rdata[6:4] == 3'h7)
    else $error("reserved bits not one");
  ovf_rise_a: assert property ($rose(irq_req.overflow_irq_req) |->
    $past(ovt) && $past(timer_counter, 2) == COUNT_MAX || $past(sov)) else $error("bad ovf rise");
  a_rise_a: assert property ($rose(irq_req.chan_a_irq_req) |-> $past(sa))
    else $error("bad chan a rise");
  b_rise_a: assert property ($rose(irq_req.chan_b_irq_req) |-> $past(sb))
    else $error("bad chan b rise");
  ovf_drop_a: assert property ($fell(irq_req.overflow_irq_req) |-> $past(co))
    else $error("bad ovf drop");
  a_drop_a: assert property ($fell(irq_req.chan_a_irq_req) |-> $past(ca))
    else $error("bad chan a drop");
  set_wins_a: assert property (evb && !en_w |=> !$fell(irq_req.chan_b_irq_req))
    else $error("clear beat a set");
  cover property ($rose(irq_req.overflow_irq_req));
  cover property ($fell(irq_req.chan_a_irq_req));
  cover property (evb && reg_req.wr);
endmodule // timer_w_irq_flags_chk
bind timer_w_irq_flags timer_w_irq_flags_chk u_timer_w_irq_flags_chk (.core_clk, .reset,
  .reg_req, .reg_rdata, .timer_counter, .count_tick, .general_reg_a, .general_reg_b,
  .chan_a_capture_select, .chan_b_capture_select, .capture_strobe, .irq_req);

/* verification/timer_w_irq_flags_test.sv */
`timescale 1ns/1ps
module timer_w_irq_flags_test import timer_w_irq_pkg::*;;
  logic core_clk = 0, reset = 1, load = 0, run = 0, tick;
  logic [15:0] start = 16'h0000, cnt_v;
  logic [15:0] gr [4] = '{16'h0005, 16'h0003, 16'h0001, 16'h0002};
  logic [3:0] sel = 4'h0, capture_strobe = 4'h0, cs = 4'h0;
  logic [7:0] reg_rdata;
  reg_req_t reg_req = '0;
  irq_req_t irq_req;
  int fails = 0, total_checks = 0, cycles = 0;
  timer_count_model u_timer_count_model (.core_clk, .reset, .load, .run, .start,
    .timer_counter(cnt_v), .count_tick(tick));
  timer_w_irq_flags u_timer_w_irq_flags (.core_clk, .reset, .reg_req, .reg_rdata,
    .timer_counter(cnt_v), .count_tick(tick), .general_reg_a(gr[0]), .general_reg_b(gr[1]),
    .general_reg_c(gr[2]), .general_reg_d(gr[3]), .chan_a_capture_select(sel[0]),
    .chan_b_capture_select(sel[1]), .chan_c_capture_select(sel[2]),
    .chan_d_capture_select(sel[3]), .capture_strobe, .irq_req);
  initial forever #2 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // read data stands only in the cycle after the strobe, so look there
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    reg_req <= '0;
    #1 chk(reg_rdata, e);
  endtask
  // cs rides along with the write so a capture can meet a clear
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    capture_strobe <= cs;
    @(posedge core_clk);
    reg_req <= '0;
    capture_strobe <= 4'h0;
    cs = 4'h0;
  endtask
  task automatic ci(input logic [7:0] e);
    #1 chk({3'h0, irq_req}, e);
  endtask
  // load then count eight steps: from FFFE this crosses the wrap and all compares
  task automatic cnt(input logic [15:0] s);
    @(posedge core_clk);
    load <= 1'b1;
    start <= s;
    @(posedge core_clk);
    load <= 1'b0;
    run <= 1'b1;
    repeat (8) @(posedge core_clk);
    run <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // traffic is about 80 cycles; a hang is cut off well past that
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(4'h0, 8'h70);
    rd(4'h1, 8'h70);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'hFF);
    wr(4'h1, 8'hFF);
    rd(4'h1, 8'h70);
    rd(4'hF, 8'h00);
    cnt(16'hFFFE);
    ci(8'h1F);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'hFF);
    wr(4'h1, 8'h0F);
    ci(8'h0F);
    rd(4'h1, 8'h7F);
    wr(4'h0, 8'h00);
    ci(8'h00);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h70);
    @(posedge core_clk);
    sel <= 4'h2;
    wr(4'h0, 8'hFF);
    cnt(16'h0000);
    rd(4'h1, 8'h7D);
    cs = 4'h2;
    wr(4'hF, 8'h00);
    rd(4'h1, 8'h7F);
    cs = 4'h2;
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h72);
    ci(8'h02);
    // every channel in capture mode: counting alone must set nothing
    @(posedge core_clk);
    sel <= 4'hF;
    cnt(16'h0000);
    rd(4'h1, 8'h72);
    cs = 4'hD;
    wr(4'hF, 8'h00);
    rd(4'h1, 8'h7F);
    ci(8'h0F);
    tally_and_finish();
  end
endmodule // timer_w_irq_flags_test
